// >>> design/hfd_dma_handshake.sv
// Purpose: DMA request and acknowledge handshake for two HDLC channels.
// Assumes: Strobes and acknowledges come from pins and are filtered here.
// Notes:   Each channel has a 16-word receive and transmit FIFO.
`timescale 1ns/100ps
module hfd_dma_handshake (
  input  wire logic                         clk_i,
  input  wire logic                         srst_i,
  input  wire logic [1:0]                   blk_size_i,
  input  wire logic [1:0][hfd_pkg::CNT_W-1:0] tx_byte_count_i,
  input  wire logic [1:0]                   tx_count_load_i,
  input  wire logic [1:0][hfd_pkg::DATA_W-1:0] rx_data_i,
  input  wire logic [1:0]                   rx_valid_i,
  output logic      [1:0]                   rx_ready_o,
  output logic      [1:0][hfd_pkg::DATA_W-1:0] tx_data_o,
  output logic      [1:0]                   tx_valid_o,
  input  wire logic [1:0]                   tx_ready_i,
  input  wire logic                         dma_ack_n_chan_a_i,
  input  wire logic                         dma_ack_n_chan_b_i,
  input  wire logic                         rd_n_i,
  input  wire logic                         wr_n_i,
  input  wire logic [hfd_pkg::DATA_W-1:0]   data_in_i,
  output logic      [hfd_pkg::DATA_W-1:0]   data_out_o,
  output logic                              data_oe_o,
  output logic                              rx_dma_req_chan_a_o,
  output logic                              rx_dma_req_chan_b_o,
  output logic                              tx_dma_req_chan_a_o,
  output logic                              tx_dma_req_chan_b_o
);
  logic [3:0][2:0]                 sync_r;
  logic [3:0][2:0]                 sync_nxt;
  logic [3:0]                      pin_raw;
  logic [3:0]                      lvl_r;
  logic [3:0]                      lvl_nxt;
  logic [hfd_pkg::DATA_W-1:0]      d_s1_r, d_s1_nxt;
  logic [hfd_pkg::DATA_W-1:0]      d_s2_r, d_s2_nxt;
  logic [hfd_pkg::DATA_W-1:0]      d_s3_r, d_s3_nxt;
  logic                            rd_n, wr_n;
  logic                            rd_n_prev_r, rd_n_prev_nxt;
  logic                            wr_n_prev_r, wr_n_prev_nxt;
  logic [1:0][hfd_pkg::DATA_W-1:0] rx_head;
  logic [1:0][4:0]                 rx_level;
  logic [1:0][4:0]                 tx_level;
  logic [1:0] ack, rd_fall, wr_rise;
  logic [1:0] rx_req_r, rx_req_nxt, tx_req_r, tx_req_nxt;
  logic [1:0][5:0] rx_left_r, rx_left_nxt;
  logic [1:0][hfd_pkg::CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
  logic [1:0] rx_pop, tx_push;
  logic [hfd_pkg::DATA_W-1:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic [5:0] blk;
  hfd_pkg::hfd_state_type [1:0] st_r, st_nxt;

  hfd_fifo_if rxf [2] ();
  hfd_fifo_if txf [2] ();

  // Pin inputs pass three flops; a change counts once stages two and three agree.
  assign pin_raw = {wr_n_i, rd_n_i, dma_ack_n_chan_b_i, dma_ack_n_chan_a_i};

  always_comb begin
    d_s1_nxt      = data_in_i;
    d_s2_nxt      = d_s1_r;
    d_s3_nxt      = d_s2_r;
    rd_n_prev_nxt = rd_n;
    wr_n_prev_nxt = wr_n;
    for (int p = 0; p < 4; p++) begin
      sync_nxt[p] = {sync_r[p][1:0], pin_raw[p]};
      lvl_nxt[p]  = (sync_r[p][1] == sync_r[p][2]) ? sync_r[p][2] : lvl_r[p];
    end
  end

  // Strobe and acknowledge pins idle high, so their flops reset to ones and no false edge follows it.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync_r      <= {4{hfd_pkg::SYNC_RST}};
      lvl_r       <= 4'hF;
      rd_n_prev_r <= 1'b1;
      wr_n_prev_r <= 1'b1;
      d_s1_r      <= '0;
      d_s2_r      <= '0;
      d_s3_r      <= '0;
    end else begin
      sync_r      <= sync_nxt;
      lvl_r       <= lvl_nxt;
      rd_n_prev_r <= rd_n_prev_nxt;
      wr_n_prev_r <= wr_n_prev_nxt;
      d_s1_r      <= d_s1_nxt;
      d_s2_r      <= d_s2_nxt;
      d_s3_r      <= d_s3_nxt;
    end
  end

  assign rd_n = lvl_r[2];
  assign wr_n = lvl_r[3];

  assign blk = hfd_pkg::blk_bytes(blk_size_i);

  assign ack = ~lvl_r[1:0];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign rd_fall[c] = ack[c] & rd_n_prev_r & ~rd_n;
    assign wr_rise[c] = ack[c] & ~wr_n_prev_r & wr_n;
    assign rx_pop[c]  = rd_fall[c] & rxf[c].rd_valid;
    assign tx_push[c] = wr_rise[c] & txf[c].wr_ready;

    assign rxf[c].wr_data  = rx_data_i[c];
    assign rxf[c].wr_valid = rx_valid_i[c];
    assign rx_ready_o[c]   = rxf[c].wr_ready;
    assign rxf[c].rd_ready = rx_pop[c];
    assign txf[c].wr_data  = d_s3_r;
    assign txf[c].wr_valid = tx_push[c];
    assign tx_data_o[c]    = txf[c].rd_data;
    assign tx_valid_o[c]   = txf[c].rd_valid;
    assign txf[c].rd_ready = tx_ready_i[c];
    // Plain copies of queue state for the shared next-state process.
    assign rx_head[c]      = rxf[c].rd_data;
    assign rx_level[c]     = rxf[c].level;
    assign tx_level[c]     = txf[c].level;

    hfd_fifo #(.WIDTH(hfd_pkg::DATA_W), .DEPTH(hfd_pkg::FIFO_DEPTH)) u_rx (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .f      (rxf[c])
    );
    hfd_fifo #(.WIDTH(hfd_pkg::DATA_W), .DEPTH(hfd_pkg::FIFO_DEPTH)) u_tx (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .f      (txf[c])
    );
  end

  always_comb begin
    dout_nxt = dout_r;
    oe_nxt   = 1'b0;
    for (int c = 0; c < 2; c++) begin
      st_nxt[c]      = st_r[c];
      rx_left_nxt[c] = rx_left_r[c];
      rx_req_nxt[c]  = rx_req_r[c];
      tx_cnt_nxt[c]  = tx_cnt_r[c];
      tx_req_nxt[c]  = tx_req_r[c];
      if (ack[c] & ~rd_n) begin
        oe_nxt = 1'b1;
      end
      if (rx_pop[c]) begin
        dout_nxt = rx_head[c];
      end
      unique case (st_r[c])
        hfd_pkg::HFD_IDLE: begin
          if ({1'b0, rx_level[c]} >= blk) begin
            st_nxt[c]      = hfd_pkg::HFD_BURST;
            rx_left_nxt[c] = blk;
            rx_req_nxt[c]  = 1'b1;
          end
        end
        hfd_pkg::HFD_BURST: begin
          if (rx_pop[c]) begin
            rx_left_nxt[c] = rx_left_r[c] - 6'h01;
            if (rx_left_r[c] == 6'h01) begin
              rx_req_nxt[c] = 1'b0;
              st_nxt[c]     = hfd_pkg::HFD_IDLE;
            end
          end
        end
      endcase
      if (tx_count_load_i[c]) begin
        tx_cnt_nxt[c] = tx_byte_count_i[c];
      end else if (tx_push[c] && tx_cnt_r[c] != hfd_pkg::CNT_RST) begin
        tx_cnt_nxt[c] = tx_cnt_r[c] - 16'h0001;
      end
      // Request while count remains and room exists.
      // Released when count is spent or the FIFO holds 15 words.
      tx_req_nxt[c] = (tx_cnt_nxt[c] != hfd_pkg::CNT_RST) && (tx_level[c] < 5'h0F);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r      <= '{hfd_pkg::HFD_IDLE, hfd_pkg::HFD_IDLE};
      rx_left_r <= '0;
      rx_req_r  <= '0;
      tx_cnt_r  <= '0;
      tx_req_r  <= '0;
      dout_r    <= '0;
      oe_r      <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      rx_left_r <= rx_left_nxt;
      rx_req_r  <= rx_req_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
      tx_req_r  <= tx_req_nxt;
      dout_r    <= dout_nxt;
      oe_r      <= oe_nxt;
    end
  end

  assign rx_dma_req_chan_a_o = rx_req_r[0];
  assign rx_dma_req_chan_b_o = rx_req_r[1];
  assign tx_dma_req_chan_a_o = tx_req_r[0];
  assign tx_dma_req_chan_b_o = tx_req_r[1];
  assign data_out_o          = dout_r;
  assign data_oe_o           = oe_r;
endmodule // hfd_dma_handshake

// >>> design/hfd_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: Depth is a power of two.
// Notes:   Read data is shown from the head word while valid is high.
`timescale 1ns/100ps
module hfd_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  hfd_fifo_if.fifo  f
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign f.wr_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
  assign f.rd_valid = (cnt_r != '0);
  assign f.rd_data  = mem[rp_r];
  assign f.level    = 5'(cnt_r);
  assign push       = f.wr_valid & f.wr_ready;
  assign pop        = f.rd_valid & f.rd_ready;

  always_comb begin
    wp_nxt  = push ? wp_r + AW'(1) : wp_r;
    rp_nxt  = pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= f.wr_data;
    end
  end
endmodule // hfd_fifo

// >>> design/hfd_fifo_if.sv
// Purpose: Carries one FIFO's fill and drain handshakes.
// Assumes: Single clock.
// Notes:   Width is fixed at the package value.
`timescale 1ns/100ps
interface hfd_fifo_if;
  logic [hfd_pkg::DATA_W-1:0] wr_data;
  logic                       wr_valid;
  logic                       wr_ready;
  logic [hfd_pkg::DATA_W-1:0] rd_data;
  logic                       rd_valid;
  logic                       rd_ready;
  logic [4:0]                 level;
  modport fifo (input wr_data, wr_valid, rd_ready, output wr_ready, rd_data, rd_valid, level);
  modport user (output wr_data, wr_valid, rd_ready, input wr_ready, rd_data, rd_valid, level);
endinterface

// >>> design/hfd_pkg.sv
// Purpose: Shared constants for the HDLC FIFO DMA handshake block.
// Assumes: Eight-bit FIFO words, two channels.
// Notes:   Block sizes are coded in two bits.
package hfd_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned CNT_W       = 16;
  localparam logic [1:0]  BLK_32      = 2'h0;
  localparam logic [1:0]  BLK_16      = 2'h1;
  localparam logic [1:0]  BLK_8       = 2'h2;
  localparam logic [1:0]  BLK_4       = 2'h3;
  localparam logic [5:0]  BLK_BYTES_32 = 6'h20;
  localparam logic [5:0]  BLK_BYTES_16 = 6'h10;
  localparam logic [5:0]  BLK_BYTES_8  = 6'h08;
  localparam logic [5:0]  BLK_BYTES_4  = 6'h04;
  localparam logic [2:0]  SYNC_RST    = 3'h7;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  typedef enum logic [0:0] {
    HFD_IDLE = 1'b0,
    HFD_BURST = 1'b1
  } hfd_state_type;

  // Block size code to byte count, used by the receive direction only.
  function automatic logic [5:0] blk_bytes(input logic [1:0] code);
    unique case (code)
      BLK_32:  blk_bytes = BLK_BYTES_32;
      BLK_16:  blk_bytes = BLK_BYTES_16;
      BLK_8:   blk_bytes = BLK_BYTES_8;
      BLK_4:   blk_bytes = BLK_BYTES_4;
    endcase
  endfunction
endpackage

// >>> testbench/hfd_dma_handshake_chk.sv
// Purpose: Port assertions for the DMA handshake block.
// Assumes: Strobes stay low at least six cycles.
// Notes:   Bound to the top module by the testbench.
`timescale 1ns/100ps
module hfd_dma_handshake_chk (
  input wire logic                           clk_i,
  input wire logic                           srst_i,
  input wire logic [1:0][hfd_pkg::CNT_W-1:0] tx_byte_count_i,
  input wire logic [1:0]                     tx_count_load_i,
  input wire logic [1:0]                     tx_valid_o,
  input wire logic                           dma_ack_n_chan_a_i,
  input wire logic                           dma_ack_n_chan_b_i,
  input wire logic                           rd_n_i,
  input wire logic                           wr_n_i,
  input wire logic                           data_oe_o,
  input wire logic                           rx_dma_req_chan_a_o,
  input wire logic                           tx_dma_req_chan_a_o
);
  logic [3:0] quiet_a_r;
  logic [3:0] quiet_a_nxt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  always_comb quiet_a_nxt = !dma_ack_n_chan_a_i ? 4'h0 : quiet_a_r + {3'h0, quiet_a_r != 4'hF};
  always_ff @(posedge clk_i) quiet_a_r <= srst_i ? 4'hF : quiet_a_nxt;
  sequence s_push_a;
    $rose(wr_n_i) && !dma_ack_n_chan_a_i && !tx_valid_o[0];
  endsequence
  a_reset_quiet: assert property ($fell(srst_i) |->
    !rx_dma_req_chan_a_o && !tx_dma_req_chan_a_o && !data_oe_o) else $error("outputs active after reset");
  a_oe_needs_read: assert property ($rose(data_oe_o) |->
    !rd_n_i && !(dma_ack_n_chan_a_i && dma_ack_n_chan_b_i)) else $error("bus driven without read select");
  a_oe_stays_off: assert property ((rd_n_i || (dma_ack_n_chan_a_i && dma_ack_n_chan_b_i)) [*8]
    |-> !data_oe_o) else $error("bus driven while unselected");
  a_tx_req_load: assert property (tx_count_load_i[0] && tx_byte_count_i[0] != 16'h0000
    && !tx_valid_o[0] |-> ##[1:2] tx_dma_req_chan_a_o) else $error("no transmit request after load");
  a_push_lands: assert property (s_push_a |-> ##[1:8] tx_valid_o[0])
    else $error("write strobe did not load transmit queue");
  a_rx_req_held: assert property ($fell(rx_dma_req_chan_a_o) |-> quiet_a_r < 4'hC)
    else $error("receive request dropped without transfer");
endmodule // hfd_dma_handshake_chk

// >>> testbench/hfd_dma_handshake_tb.sv
// Purpose: Self-checking bench for the DMA handshake block.
// Assumes: Inputs change on falling clock edges.
// Notes:   A behavioural DMA controller moves every byte.
`timescale 1ns/100ps
module hfd_dma_handshake_tb;
  logic                            clk_i = 1'b0;
  logic                            srst_i = 1'b1;
  logic [1:0]                      blk_size_i = 2'h1;
  logic [1:0]                      tx_count_load_i = 2'h0;
  logic [1:0]                      rx_valid_i = 2'h0;
  logic [1:0]                      tx_ready_i = 2'h0;
  logic [1:0][hfd_pkg::CNT_W-1:0]  tx_byte_count_i = '0;
  logic [1:0][hfd_pkg::DATA_W-1:0] rx_data_i = '0;
  logic [1:0][hfd_pkg::DATA_W-1:0] tx_data_o;
  logic [1:0]                      rx_ready_o;
  logic [1:0]                      tx_valid_o;
  logic [1:0]                      ack_n;
  logic [7:0]                      data_in;
  logic [7:0]                      data_out;
  logic                            rd_n;
  logic                            wr_n;
  logic                            data_oe_o;
  wire  [3:0]                      req;
  int                              fails = 0;
  int                              samples_checked = 0;
  hfd_dma_handshake dut (.clk_i, .srst_i, .blk_size_i, .tx_byte_count_i, .tx_count_load_i, .rx_data_i,
    .rx_valid_i, .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_ready_i, .dma_ack_n_chan_a_i(ack_n[0]),
    .dma_ack_n_chan_b_i(ack_n[1]), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_in_i(data_in), .data_out_o(data_out),
    .data_oe_o, .rx_dma_req_chan_a_o(req[0]), .rx_dma_req_chan_b_o(req[1]), .tx_dma_req_chan_a_o(req[2]),
    .tx_dma_req_chan_b_o(req[3]));
  hfd_dma_model dma (.clk_i, .data_out_i(data_out), .ack_n_o(ack_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(data_in));
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_req(input int idx, input logic lvl);
    for (int n = 0; n < 40 && req[idx] !== lvl; n++) @(negedge clk_i);
    chk("request level", {15'h0, lvl}, {15'h0, req[idx]});
  endtask
  task automatic push_rx(input int ch, input logic [1:0] code, input int first, input int last);
    for (int i = first; i < last; i++) begin
      while (rx_ready_o[ch] !== 1'b1) @(negedge clk_i);
      rx_data_i[ch] <= {code, i[5:0]};
      rx_valid_i[ch] <= 1'b1;
      @(negedge clk_i);
    end
    rx_valid_i[ch] <= 1'b0;
  endtask
  task automatic drain(input int ch, input int first, input int last);
    for (int i = first; i < last; i++) begin
      while (tx_valid_o[ch] !== 1'b1) @(negedge clk_i);
      chk("tx byte", {8'h0, 8'h80 + i[7:0]}, {8'h0, tx_data_o[ch]});
      tx_ready_i[ch] <= 1'b1;
      @(negedge clk_i);
    end
    tx_ready_i[ch] <= 1'b0;
  endtask
  task automatic t_rx(input logic [1:0] code);
    int ch;
    int n;
    logic [7:0] q;
    ch = code[0];
    n = 32 >> code;
    dma.slow = (code == 2'h3) ? 4 : 0;
    blk_size_i <= code;
    push_rx(ch, code, 0, n - 1);
    repeat (8) @(negedge clk_i);
    chk("rx short block", 16'h0, {15'h0, req[ch]});
    if (code == 2'h1) blk_size_i <= 2'h0;
    push_rx(ch, code, n - 1, n);
    if (code == 2'h1) begin
      repeat (8) @(negedge clk_i);
      chk("rx block of 32", 16'h0, {15'h0, req[ch]});
      chk("rx ready when full", 16'h0, {15'h0, rx_ready_o[ch]});
      blk_size_i <= code;
    end
    wait_req(ch, 1'b1);
    dma.xfer(1 - ch, 1'b0, 8'h00, q);
    chk("rx other select", 16'h1, {15'h0, req[ch]});
    for (int i = 0; i < n; i++) begin
      chk("rx request held", 16'h1, {15'h0, req[ch]});
      dma.xfer(ch, 1'b0, 8'h00, q);
      chk("rx byte", {8'h0, code, i[5:0]}, {8'h0, q});
      chk("read bus released", 16'h0, {15'h0, data_oe_o});
    end
    wait_req(ch, 1'b0);
    $display("test rx block %0d done", n);
  endtask
  task automatic t_tx(input int ch);
    int k;
    logic [7:0] q;
    tx_byte_count_i[ch] <= 16'h0010;
    tx_count_load_i[ch] <= 1'b1;
    @(negedge clk_i);
    tx_count_load_i[ch] <= 1'b0;
    wait_req(2 + ch, 1'b1);
    for (k = 0; k < 20 && req[2 + ch] === 1'b1; k++) dma.xfer(ch, 1'b1, 8'h80 + k[7:0], q);
    chk("tx writes to near full", 16'h000F, k[15:0]);
    drain(ch, 0, 15);
    wait_req(2 + ch, 1'b1);
    dma.xfer(ch, 1'b1, 8'h8F, q);
    wait_req(2 + ch, 1'b0);
    drain(ch, 15, 16);
    $display("test tx channel %0d done", ch);
  endtask
  task automatic t_mid_reset();
    tx_byte_count_i[1] <= 16'h0003;
    tx_count_load_i[1] <= 1'b1;
    @(negedge clk_i);
    tx_count_load_i[1] <= 1'b0;
    wait_req(3, 1'b1);
    srst_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    chk("requests after mid reset", 16'h0, {12'h0, req});
    repeat (4) @(negedge clk_i);
    chk("tx request after mid reset", 16'h0, {15'h0, req[3]});
    $display("test mid reset done");
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    chk("requests after reset", 16'h0, {12'h0, req});
    chk("read bus after reset", 16'h0, {7'h0, data_oe_o, data_out});
    $display("test reset done");
    for (int c = 1; c < 4; c++) t_rx(c[1:0]);
    t_tx(0);
    t_tx(1);
    t_mid_reset();
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    $display("mismatch watchdog expected finish seen timeout");
    stop_test();
  end
endmodule // hfd_dma_handshake_tb
bind hfd_dma_handshake hfd_dma_handshake_chk chk (.clk_i, .srst_i, .tx_byte_count_i, .tx_count_load_i, .tx_valid_o,
  .dma_ack_n_chan_a_i, .dma_ack_n_chan_b_i, .rd_n_i, .wr_n_i, .data_oe_o, .rx_dma_req_chan_a_o, .tx_dma_req_chan_a_o);

// >>> testbench/hfd_dma_model.sv
// Purpose: Behavioural DMA controller facing the handshake block.
// Assumes: Callers enter its task on a falling clock edge.
// Notes:   Setting slow stretches each strobe.
`timescale 1ns/100ps
module hfd_dma_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] data_out_i,
  output logic      [1:0] ack_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic      [7:0] data_o
);
  int slow = 0;
  initial begin
    ack_n_o = 2'h3;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = 8'h5A;
  end
  task automatic xfer(input int ch, input bit wr, input logic [7:0] d, output logic [7:0] q);
    ack_n_o[ch] <= 1'b0;
    data_o <= d;
    repeat (2 + slow) @(negedge clk_i);
    if (wr) wr_n_o <= 1'b0;
    else rd_n_o <= 1'b0;
    repeat (6 + slow) @(negedge clk_i);
    q = data_out_i;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    repeat (6) @(negedge clk_i);
    ack_n_o[ch] <= 1'b1;
    data_o <= ~d;
    @(negedge clk_i);
  endtask
endmodule // hfd_dma_model
